/* File: design/dl_count_pkg.sv */
// Constants for the data link message buffer and count block.
// Assumes a 32-bit APB master and one 100 MHz clock shared by all logic.
package dl_count_pkg;

    // ----------------------------------------------------------------
    // Bus and field widths
    // ----------------------------------------------------------------
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam int COUNT_W = 7;
    localparam int INDEX_W = 10;
    localparam int STAT_W = 3;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [INDEX_W-1:0] TX_INDEX = 10'h114;
    localparam logic [INDEX_W-1:0] RX_INDEX = 10'h115;
    localparam logic [INDEX_W-1:0] STAT_INDEX = 10'h11C;
    localparam logic [INDEX_W-1:0] MASK_INDEX = 10'h11D;
    localparam logic [INDEX_W-1:0] CTRL_INDEX = 10'h11E;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SEL_BIT = 7;
    localparam int TX_SIGTYPE_BIT = 0;
    localparam int RX_SIGTYPE_BIT = 1;
    localparam int TX_EOT_BIT = 0;
    localparam int RX_EOT_BIT = 1;
    localparam int RX_MSG_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TX_REG_RESET = 8'h00;
    localparam logic [7:0] RX_REG_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;

    typedef enum logic [2:0] {
        SEL_TX = 3'b000,
        SEL_RX = 3'b001,
        SEL_STAT = 3'b010,
        SEL_MASK = 3'b011,
        SEL_CTRL = 3'b100,
        SEL_NONE = 3'b111
    } regSel_e;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } txState_e;

endpackage : dl_count_pkg

/* File: design/repeat_count_if.sv */
// Carrier between the block and its repeat counters.
// Assumes owner and counter share one clock.
`timescale 1ns/1ps
interface repeat_count_if;
    logic [dl_count_pkg::COUNT_W-1:0] target;
    logic tick;
    logic clear;
    logic hit;

    modport owner (output target, output tick, output clear, input hit);
    modport counter (input target, input tick, input clear, output hit);
endinterface : repeat_count_if

/* File: design/repeat_counter.sv */
// Counts message repetitions and flags the one that reaches the target.
// Assumes tick and clear come from logic on the same clock.
`timescale 1ns/1ps
module repeat_counter (
    input wire logic clk,
    input wire logic reset,
    repeat_count_if.counter cnt
);
    import dl_count_pkg::*;

    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [COUNT_W:0] nextCount;

    // Target zero never hits: repetition without limit
    always_comb begin
        nextCount = {1'b0, count_q} + {{COUNT_W{1'b0}}, 1'b1};
        cnt.hit = cnt.tick && (cnt.target != '0)
            && (nextCount == {1'b0, cnt.target});
        count_d = count_q;
        if (cnt.clear || cnt.hit) begin
            count_d = '0;
        end else if (cnt.tick) begin
            count_d = nextCount[COUNT_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : repeat_counter

/* File: design/dl_msg_count.sv */
// Buffer selection and message count logic of data link controller one.
// Assumes an APB master on clk; link engines on clk give one-cycle pulses.
//
// Behaviour
// - Writing buffer select sends the message of buffer zero or one.
// - Reading buffer select returns the next available transmit buffer.
// - While a buffer is still in use, reads return the other buffer.
// - Bit-oriented: send count times, then end-of-transfer event and stop.
// - Bit-oriented with count zero repeats the message until another send is queued.
// - Message-oriented: count is length in octets, header in, checksum out.
// - Receive pointer names the buffer holding the newest message.
// - Bit-oriented receive: end-of-transfer once received count times.
// - Bit-oriented receive with count zero never ends the transfer.
// - Message-oriented receive writes stored message size into count.
`timescale 1ns/1ps
module dl_msg_count (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dl_count_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [dl_count_pkg::APB_DATA_W-1:0] pwdata,
    output logic [dl_count_pkg::APB_DATA_W-1:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    output logic irq_q,
    output logic txActive_q,
    output logic txBufferSel_q,
    output logic txBitOriented_q,
    output logic [dl_count_pkg::COUNT_W-1:0] txLength_q,
    input wire logic txMessageSent,
    output logic rxBitOriented_q,
    input wire logic rxMessageDone,
    input wire logic rxMessageBuffer,
    input wire logic [dl_count_pkg::COUNT_W-1:0] rxMessageBytes
);
    import dl_count_pkg::*;

    function automatic regSel_e decode(input logic [APB_ADDR_W-1:0] a);
        regSel_e s;
        s = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[APB_ADDR_W-1:2])
                TX_INDEX: s = SEL_TX;
                RX_INDEX: s = SEL_RX;
                STAT_INDEX: s = SEL_STAT;
                MASK_INDEX: s = SEL_MASK;
                CTRL_INDEX: s = SEL_CTRL;
                default: s = SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    repeat_count_if txCnt ();
    repeat_count_if rxCnt ();

    repeat_counter u_tx_counter (
        .clk(clk),
        .reset(reset),
        .cnt(txCnt.counter)
    );

    repeat_counter u_rx_counter (
        .clk(clk),
        .reset(reset),
        .cnt(rxCnt.counter)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    txState_e txState_q, txState_d;
    logic txActive_d, txBufferSel_d, txBitOriented_d;
    logic [COUNT_W-1:0] txLength_d, txCount_q, txCount_d;
    logic txPend_q, txPend_d, txPendBuf_q, txPendBuf_d;
    logic txHint_q, txHint_d;
    logic rxLatest_q, rxLatest_d;
    logic [COUNT_W-1:0] rxCount_q, rxCount_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [STAT_W-1:0] status_q, status_d, mask_q, mask_d, statusSet;
    logic [APB_DATA_W-1:0] prdata_d;
    logic pready_d, pslverr_d, irq_d, rxBitOriented_d;

    // ----------------------------------------------------------------
    // Bus and transmit/receive next state
    // ----------------------------------------------------------------
    regSel_e regSel;
    logic commit, wrTx, wrRx, wSel, txAccept, txFinish, txGo, txGoBuf;
    logic txAvail;
    logic [1:0] txBusy;

    always_comb begin
        regSel = decode(paddr);
        // Answer one cycle into the access phase; write effects at the next edge, where ready is sampled
        commit = psel && penable && pready_q;
        pready_d = psel && penable && !pready_q;
        pslverr_d = pready_d && (regSel == SEL_NONE);
        wrTx = commit && pwrite && (regSel == SEL_TX);
        wrRx = commit && pwrite && (regSel == SEL_RX);
        wSel = pwdata[SEL_BIT];
        txBusy[0] = (txActive_q && !txBufferSel_q)
            || (txPend_q && !txPendBuf_q);
        txBusy[1] = (txActive_q && txBufferSel_q)
            || (txPend_q && txPendBuf_q);
        txAvail = txBusy[txHint_q] ? !txHint_q : txHint_q;

        ctrl_d = ctrl_q;
        mask_d = mask_q;
        statusSet = '0;
        if (commit && pwrite && (regSel == SEL_CTRL)) begin
            ctrl_d = pwdata[1:0];
        end
        if (commit && pwrite && (regSel == SEL_MASK)) begin
            mask_d = pwdata[STAT_W-1:0];
        end

        // Transmit side
        txState_d = txState_q;
        txBufferSel_d = txBufferSel_q;
        txBitOriented_d = txBitOriented_q;
        txLength_d = txLength_q;
        txPend_d = txPend_q;
        txPendBuf_d = txPendBuf_q;
        txHint_d = txHint_q;
        txCount_d = wrTx ? pwdata[COUNT_W-1:0] : txCount_q;
        // A select aimed at a busy buffer or with one queued is dropped
        txAccept = wrTx && !txBusy[wSel] && !txPend_q;
        txCnt.target = txLength_q;
        txCnt.tick = txActive_q && txBitOriented_q && txMessageSent;
        txFinish = txActive_q && txMessageSent
            && (!txBitOriented_q || txCnt.hit
            || (txLength_q == '0 && txPend_q));
        txGo = 1'b0;
        txGoBuf = wSel;
        if (txFinish) begin
            statusSet[TX_EOT_BIT] = 1'b1;
            txState_d = TX_IDLE;
            if (txPend_q) begin
                txGo = 1'b1;
                txGoBuf = txPendBuf_q;
                txPend_d = 1'b0;
            end
        end
        if (txAccept) begin
            txHint_d = !wSel;
            if (!txActive_q || txFinish) begin
                txGo = 1'b1;
            end else begin
                txPend_d = 1'b1;
                txPendBuf_d = wSel;
            end
        end
        if (txGo) begin
            txState_d = TX_SEND;
            txBufferSel_d = txGoBuf;
            txBitOriented_d = !ctrl_q[TX_SIGTYPE_BIT];
            txLength_d = txCount_d;
        end
        txCnt.clear = txGo;
        txActive_d = (txState_d == TX_SEND);

        // Receive side; a message event beats a same-cycle software write to the pointer, and to the count only when message-oriented
        rxBitOriented_d = !ctrl_d[RX_SIGTYPE_BIT];
        rxLatest_d = rxLatest_q;
        rxCount_d = rxCount_q;
        if (wrRx) begin
            rxLatest_d = pwdata[SEL_BIT];
            rxCount_d = pwdata[COUNT_W-1:0];
        end
        rxCnt.target = rxCount_q;
        rxCnt.clear = wrRx;
        rxCnt.tick = rxMessageDone && rxBitOriented_q;
        if (rxMessageDone) begin
            rxLatest_d = rxMessageBuffer;
            if (!rxBitOriented_q) begin
                rxCount_d = rxMessageBytes;
                statusSet[RX_MSG_BIT] = 1'b1;
            end
        end
        statusSet[RX_EOT_BIT] = rxCnt.hit;

        // Sticky events: a set in the clearing cycle survives
        status_d = status_q;
        if (commit && pwrite && (regSel == SEL_STAT)) begin
            status_d = status_q & ~pwdata[STAT_W-1:0];
        end
        status_d = status_d | statusSet;
        irq_d = |(status_d & mask_d);

        prdata_d = '0;
        if (pready_d && !pwrite) begin
            case (regSel)
                SEL_TX: prdata_d = {24'h0, txAvail, txCount_q};
                SEL_RX: prdata_d = {24'h0, rxLatest_q, rxCount_q};
                SEL_STAT: prdata_d = {29'h0, status_q};
                SEL_MASK: prdata_d = {29'h0, mask_q};
                SEL_CTRL: prdata_d = {30'h0, ctrl_q};
                default: prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            txState_q <= TX_IDLE;
            txActive_q <= 1'b0;
            txBufferSel_q <= 1'b0;
            txBitOriented_q <= 1'b0;
            txLength_q <= '0;
            txCount_q <= TX_REG_RESET[COUNT_W-1:0];
            txHint_q <= TX_REG_RESET[SEL_BIT];
            txPend_q <= 1'b0;
            txPendBuf_q <= 1'b0;
            rxLatest_q <= RX_REG_RESET[SEL_BIT];
            rxCount_q <= RX_REG_RESET[COUNT_W-1:0];
            rxBitOriented_q <= 1'b1;
            ctrl_q <= CTRL_RESET;
            status_q <= STAT_RESET;
            mask_q <= STAT_RESET;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            txState_q <= txState_d;
            txActive_q <= txActive_d;
            txBufferSel_q <= txBufferSel_d;
            txBitOriented_q <= txBitOriented_d;
            txLength_q <= txLength_d;
            txCount_q <= txCount_d;
            txHint_q <= txHint_d;
            txPend_q <= txPend_d;
            txPendBuf_q <= txPendBuf_d;
            rxLatest_q <= rxLatest_d;
            rxCount_q <= rxCount_d;
            rxBitOriented_q <= rxBitOriented_d;
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_tx_sel_follows: assert property (
        txGo |=> txActive_q && txBufferSel_q == $past(txGoBuf))
        else $error("transmit buffer not taken from select");

    a_tx_avail_read: assert property (
        pready_d && !pwrite && regSel == SEL_TX
        |=> prdata_q[SEL_BIT] == $past(txAvail) && pready_q)
        else $error("select read does not show next available buffer");

    a_tx_other_free: assert property (
        txBusy == 2'b01 |-> txAvail)
        else $error("busy buffer zero offered as available");

    a_tx_busy_refused: assert property (
        wrTx && txBusy[wSel] |=> txBufferSel_q == $past(txBufferSel_q)
        || $past(txFinish))
        else $error("write to busy buffer changed transmit buffer");

    a_tx_bo_end: assert property (
        txActive_q && txBitOriented_q && txMessageSent && txCnt.hit
        && !txPend_q && !wrTx |=> !txActive_q && status_q[TX_EOT_BIT])
        else $error("repeat count reached without stop and event");

    a_tx_bo_forever: assert property (
        txActive_q && txBitOriented_q && txLength_q == '0 && !txPend_q
        |=> txActive_q)
        else $error("unlimited bit-oriented send stopped");

    a_tx_mo_single: assert property (
        txActive_q && !txBitOriented_q && txMessageSent && !txPend_q
        && !wrTx |=> !txActive_q)
        else $error("message-oriented send did not end after one");

    a_rx_pointer: assert property (
        rxMessageDone |=> rxLatest_q == $past(rxMessageBuffer))
        else $error("receive pointer not on newest buffer");

    a_rx_bo_eot: assert property (
        rxCnt.hit |=> status_q[RX_EOT_BIT]
        && (irq_q || !mask_q[RX_EOT_BIT]))
        else $error("receive end of transfer missed");

    a_rx_zero_quiet: assert property (
        rxCount_q == '0 |-> !rxCnt.hit)
        else $error("end of transfer with count zero");

    a_rx_mo_size: assert property (
        rxMessageDone && !rxBitOriented_q
        |=> rxCount_q == $past(rxMessageBytes) && status_q[RX_MSG_BIT])
        else $error("received size not stored");

endmodule : dl_msg_count

/* File: tb/link_partner.sv */
// Far-end transmit engine model: reports one message sent per GAP+1 cycles.
// Assumes the block's transmit outputs are registered on clk.
`timescale 1ns/1ps
module link_partner #(
    parameter int GAP = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic txActive_q,
    output logic txMessageSent
);
    // ----------------------------------------------------------------
    // Message pacing
    // ----------------------------------------------------------------
    int cnt;

    // Restart pacing after each pulse so a queued send is never early
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            txMessageSent <= 1'b0;
        end else if (txActive_q && !txMessageSent) begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            txMessageSent <= (cnt == GAP - 1);
        end else begin
            cnt <= 0;
            txMessageSent <= 1'b0;
        end
    end
endmodule : link_partner

/* File: tb/dl_msg_count_tb.sv */
// Self-checking bench for the data link message count block.
// Assumes the design package and the link partner model compile first.
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errorCnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module dl_msg_count_tb;
    import dl_count_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [11:0] TX_A = {TX_INDEX, 2'b00};
    localparam logic [11:0] RX_A = {RX_INDEX, 2'b00};
    localparam logic [11:0] STAT_A = {STAT_INDEX, 2'b00};
    localparam logic [11:0] MASK_A = {MASK_INDEX, 2'b00};
    localparam logic [11:0] CTRL_A = {CTRL_INDEX, 2'b00};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q, txActive_q, txBufferSel_q;
    logic txBitOriented_q, txMessageSent, rxBitOriented_q;
    logic [6:0] txLength_q;
    logic rxMessageDone = 1'b0;
    logic rxMessageBuffer = 1'b0;
    logic [6:0] rxMessageBytes = '0;
    int errorCnt = 0;
    int numChecks = 0;
    int sentCnt = 0;

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (txMessageSent && txActive_q) begin
            sentCnt <= sentCnt + 1;
        end
    end

    dl_msg_count dl_msg_count_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .irq_q(irq_q), .txActive_q(txActive_q),
        .txBufferSel_q(txBufferSel_q), .txBitOriented_q(txBitOriented_q),
        .txLength_q(txLength_q), .txMessageSent(txMessageSent),
        .rxBitOriented_q(rxBitOriented_q), .rxMessageDone(rxMessageDone),
        .rxMessageBuffer(rxMessageBuffer), .rxMessageBytes(rxMessageBytes));

    link_partner link_partner_i (.clk(clk), .reset(reset),
        .txActive_q(txActive_q), .txMessageSent(txMessageSent));

    // ----------------------------------------------------------------
    // Bus and link tasks
    // ----------------------------------------------------------------
    // Request stands until ready is seen high at a rising edge;
    // only the watchdog ends a wait that never gets an answer
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, {24'h0, x})
    endtask : rdChk

    task automatic waitTx(input logic lvl);
        int n;
        n = 0;
        while (txActive_q !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        `CHK(txActive_q, lvl)
    endtask : waitTx

    task automatic rxPulse(input logic b, input logic [6:0] n);
        @(posedge clk);
        rxMessageDone <= 1'b1;
        rxMessageBuffer <= b;
        rxMessageBytes <= n;
        @(posedge clk);
        rxMessageDone <= 1'b0;
        rxMessageBuffer <= ~b;
        rxMessageBytes <= ~n;
    endtask : rxPulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic tResetMap();
        logic [31:0] r;
        logic e;
        `CHK(rxBitOriented_q, 1'b1)
        rdChk(TX_A, 8'h00);
        rdChk(RX_A, 8'h00);
        rdChk(STAT_A, 8'h00);
        apb(1'b0, 12'h000, 32'h0, r, e);
        `CHK({e, r}, 33'h100000000)
    endtask : tResetMap

    task automatic tTxBit();
        wr(CTRL_A, 32'h0);
        wr(MASK_A, 32'h7);
        sentCnt = 0;
        wr(TX_A, 32'h03);
        waitTx(1'b1);
        `CHK(txBufferSel_q, 1'b0)
        `CHK(txBitOriented_q, 1'b1)
        `CHK(txLength_q, 7'h03)
        rdChk(TX_A, 8'h83);
        waitTx(1'b0);
        `CHK(sentCnt, 3)
        rdChk(STAT_A, 8'h01);
        `CHK(irq_q, 1'b1)
        wr(STAT_A, 32'h1);
        repeat (2) @(negedge clk);
        `CHK(irq_q, 1'b0)
    endtask : tTxBit

    task automatic tTxMsg();
        wr(CTRL_A, 32'h1);
        sentCnt = 0;
        wr(TX_A, 32'hFF);
        waitTx(1'b1);
        `CHK(txBufferSel_q, 1'b1)
        `CHK(txBitOriented_q, 1'b0)
        `CHK(txLength_q, 7'h7F)
        waitTx(1'b0);
        `CHK(sentCnt, 1)
        rdChk(STAT_A, 8'h01);
        rdChk(TX_A, 8'h7F);
        wr(STAT_A, 32'h1);
    endtask : tTxMsg

    task automatic tTxEndless();
        wr(CTRL_A, 32'h0);
        sentCnt = 0;
        wr(TX_A, 32'h00);
        waitTx(1'b1);
        repeat (40) @(negedge clk);
        `CHK(txActive_q, 1'b1)
        `CHK(sentCnt > 5, 1'b1)
        rdChk(STAT_A, 8'h00);
        wr(TX_A, 32'h81);
        repeat (30) @(negedge clk);
        `CHK(txActive_q, 1'b0)
        rdChk(STAT_A, 8'h01);
        wr(STAT_A, 32'h1);
    endtask : tTxEndless

    task automatic tRx();
        wr(MASK_A, 32'h0);
        wr(CTRL_A, 32'h2);
        rxPulse(1'b1, 7'h2A);
        rdChk(RX_A, 8'hAA);
        rdChk(STAT_A, 8'h04);
        `CHK(irq_q, 1'b0)
        wr(MASK_A, 32'h7);
        repeat (2) @(negedge clk);
        `CHK(irq_q, 1'b1)
        wr(STAT_A, 32'h7);
        wr(CTRL_A, 32'h0);
        wr(RX_A, 32'h02);
        rxPulse(1'b0, 7'h05);
        rdChk(STAT_A, 8'h00);
        rxPulse(1'b0, 7'h05);
        rdChk(STAT_A, 8'h02);
        wr(STAT_A, 32'h7);
        wr(RX_A, 32'h00);
        repeat (3) rxPulse(1'b1, 7'h05);
        rdChk(STAT_A, 8'h00);
        rdChk(RX_A, 8'h80);
    endtask : tRx

    task automatic conclude();
        $display("checks %0d, mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        #100000;
        errorCnt++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        tResetMap();
        tTxBit();
        tTxMsg();
        tTxEndless();
        tRx();
        conclude();
    end
endmodule : dl_msg_count_tb
